// ---- core/emp_pkg.sv ----
// Shared types and constants for the external memory strobe and pin block.
// Assumes a single 125 MHz system clock and plain control ports.
package emp_pkg;

   // Clock period in ns, for reference by time counts
   localparam int CLK_PERIOD_NS = 8;

   // Width of the memory clock divider field
   localparam int DIV_W = 2;

   // Reset values of the control inputs' registered copies
   localparam logic [1:0] DIV_RESET = 2'h0;

   // Request kinds from the memory request path
   typedef enum logic [3:0] {
      EMP_CMD_NONE,
      EMP_CMD_ASYNC_READ,
      EMP_CMD_ASYNC_WRITE,
      EMP_CMD_SD_ACTIVATE,
      EMP_CMD_SD_READ,
      EMP_CMD_SD_WRITE,
      EMP_CMD_SD_PRECHARGE_ALL,
      EMP_CMD_SD_REFRESH,
      EMP_CMD_SD_MODE_SET
   } emp_cmd_t;

   // One request from the host path
   typedef struct packed {
      emp_cmd_t cmd;
      logic row_bit_ten;
      logic auto_precharge;
   } emp_req_t;

   // Pin group with data value and output enable (low = driven)
   typedef struct packed {
      logic val;
      logic oe_n;
   } emp_pin_t;

   // Clock-enable pin selection
   typedef enum logic {
      EMP_CKE_ON_FLAG,
      EMP_CKE_ON_GPIO
   } emp_cke_sel_t;

endpackage

// ---- core/emp_sync.sv ----
// Two flip-flop synchroniser for one level input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module emp_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Level in and out
   input wire logic din,
   output logic dout
);
   // Both stages in one struct
   typedef struct packed {
      logic s1;
      logic s2;
   } emp_sync_st_t;

   emp_sync_st_t st;
   emp_sync_st_t next_st;

   // First stage read only by the second
   always_comb begin
      next_st.s1 = din;
      next_st.s2 = st.s1;
   end

   // Register stages; reset as idle-high ready
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= 2'h3;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.s2;
endmodule // emp_sync

// ---- core/emp_clkdiv.sv ----
// Memory clock generator: divides clk and holds high when off.
// Assumes divider changes may glitch one period; software changes it idle.
`timescale 1ns/1ps
module emp_clkdiv (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic clock_on,
   input wire logic [1:0] divider,
   // Output
   output logic clk_out
);
   // Divider state
   typedef struct packed {
      logic [1:0] cnt;
      logic level;
   } emp_div_st_t;

   emp_div_st_t st;
   emp_div_st_t next_st;

   // Half period = divider + 1 cycles of clk
   always_comb begin
      next_st = st;
      if (!clock_on) begin
         // Held high while disabled
         next_st.cnt = 2'h0;
         next_st.level = 1'b1;
      end else if (st.cnt >= divider) begin
         // Toggle at divider-selected rate
         next_st.cnt = 2'h0;
         next_st.level = ~st.level;
      end else begin
         next_st.cnt = st.cnt + 2'h1;
      end
   end

   // Register state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= 3'h1;
      end else begin
         st <= next_st;
      end
   end

   assign clk_out = st.level;

   // Off means high within two cycles
   clk_held_high_a: assert property (@(posedge clk) disable iff (!arst_n)
      !clock_on ##1 !clock_on |-> clk_out)
      else $error("memory clock not held high when off");

   // Divider zero gives toggling every cycle
   clk_toggles_a: assert property (@(posedge clk) disable iff (!arst_n)
      (clock_on && divider == 2'h0) [*3] |-> clk_out != $past(clk_out))
      else $error("memory clock not toggling at divide one");
endmodule // emp_clkdiv

// ---- core/emp_pins.sv ----
// Functional notes
// - Output enable low during async reads
// - Read strobe low during async reads
// - Write strobe low during async writes
// - Bus release floats async strobes
// - Bus release floats general interface outputs; general_io_pin_four stays driven through release here
// - Row strobe low for activate, precharge, refresh, mode
// - Column strobe low for read, write, refresh, mode
// - Write line low for write, precharge, mode
// - A10 carries row bit on activate
// - A10 is auto-precharge on read/write
// - A10 high on precharge-all
// - Memory clock toggles when on, else high
// - Divider field selects memory clock rate
// - Release floats sdram pins except clock enable
// - Clock enable on flag or general pin
// - Data bus undriven between transfers
//
// Pin-level strobe and command logic of the external memory interface.
// Assumes one request per idle slot from the host path; data bus keepers
// sit outside and hold the bus when this block stops driving it.
`timescale 1ns/1ps
module emp_pins (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Host request path
   input wire logic req_valid,
   input wire emp_pkg::emp_req_t req,
   input wire logic [1:0] async_hold_cycles,
   input wire logic [15:0] write_data,
   output logic req_ready,
   output logic access_done,
   // Control bits
   input wire logic bus_release,
   input wire logic memory_clock_on,
   input wire logic [1:0] memory_clock_divider,
   input wire logic sdram_cke,
   input wire emp_pkg::emp_cke_sel_t cke_select,
   // Asynchronous memory pins
   input wire logic async_ready_in,
   output logic async_output_enable_n,
   output logic async_output_enable_oe_n,
   output logic async_read_strobe_n,
   output logic async_read_strobe_oe_n,
   output logic async_write_strobe_n,
   output logic async_write_strobe_oe_n,
   // SDRAM pins
   output logic sdram_row_strobe_n,
   output logic sdram_column_strobe_n,
   output logic sdram_write_line_n,
   output logic sdram_addr_line_ten,
   output logic sdram_pins_oe_n,
   output logic memory_clock_out,
   output logic memory_clock_oe_n,
   // Clock-enable carrier pins, never floated
   output logic external_flag_pin,
   output logic general_io_pin_four,
   // Data bus
   output logic [15:0] data_out,
   output logic data_oe_n
);
   // Access phases
   typedef enum logic [1:0] {
      EMP_IDLE,
      EMP_ASYNC,
      EMP_SDCMD
   } emp_phase_t;

   // Whole state of the pin block
   typedef struct packed {
      emp_phase_t phase;
      emp_pkg::emp_req_t cur;
      logic [1:0] hold;
      logic done;
      logic oe_n;
      logic rd_n;
      logic we_n;
      logic ras_n;
      logic cas_n;
      logic swe_n;
      logic a10;
      logic [15:0] wdata;
      logic drive_data;
      logic flag;
      logic gpio;
   } emp_st_t;

   emp_st_t st;
   emp_st_t next_st;
   logic ready_sync;
   logic clk_div_out;
   logic is_read;
   logic is_write;

   // Ready comes from a pin, so it is synchronised first
   emp_sync u_ready_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din(async_ready_in),
      .dout(ready_sync)
   );

   // Memory clock generator
   emp_clkdiv u_clkdiv (
      .clk(clk),
      .arst_n(arst_n),
      .clock_on(memory_clock_on),
      .divider(memory_clock_divider),
      .clk_out(clk_div_out)
   );

   // Accept new work only when idle and bus is ours
   assign req_ready = (st.phase == EMP_IDLE) && !bus_release;
   assign is_read = req.cmd == emp_pkg::EMP_CMD_ASYNC_READ;
   assign is_write = req.cmd == emp_pkg::EMP_CMD_ASYNC_WRITE;

   // Next-state logic for strobes and commands
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      // Clock enable follows software on the chosen pin
      next_st.flag = (cke_select == emp_pkg::EMP_CKE_ON_FLAG) ?
         sdram_cke : 1'b0;
      next_st.gpio = (cke_select == emp_pkg::EMP_CKE_ON_GPIO) ?
         sdram_cke : 1'b0;
      unique case (st.phase)
         EMP_IDLE: begin
            // All strobes rest high between accesses
            next_st.oe_n = 1'b1;
            next_st.rd_n = 1'b1;
            next_st.we_n = 1'b1;
            next_st.ras_n = 1'b1;
            next_st.cas_n = 1'b1;
            next_st.swe_n = 1'b1;
            next_st.a10 = 1'b0;
            next_st.drive_data = 1'b0;
            if (req_valid && req_ready) begin
               next_st.cur = req;
               next_st.hold = async_hold_cycles;
               if (is_read || is_write) begin
                  next_st.phase = EMP_ASYNC;
                  next_st.oe_n = !is_read;
                  next_st.rd_n = !is_read;
                  next_st.we_n = !is_write;
                  next_st.drive_data = is_write;
                  next_st.wdata = write_data;
               end else if (req.cmd != emp_pkg::EMP_CMD_NONE) begin
                  next_st.phase = EMP_SDCMD;
                  unique case (req.cmd)
                     emp_pkg::EMP_CMD_SD_ACTIVATE: begin
                        next_st.ras_n = 1'b0;
                        next_st.a10 = req.row_bit_ten;
                     end
                     emp_pkg::EMP_CMD_SD_READ: begin
                        next_st.cas_n = 1'b0;
                        next_st.a10 = req.auto_precharge;
                     end
                     emp_pkg::EMP_CMD_SD_WRITE: begin
                        next_st.cas_n = 1'b0;
                        next_st.swe_n = 1'b0;
                        next_st.a10 = req.auto_precharge;
                        next_st.drive_data = 1'b1;
                        next_st.wdata = write_data;
                     end
                     emp_pkg::EMP_CMD_SD_PRECHARGE_ALL: begin
                        next_st.ras_n = 1'b0;
                        next_st.swe_n = 1'b0;
                        next_st.a10 = 1'b1;
                     end
                     emp_pkg::EMP_CMD_SD_REFRESH: begin
                        next_st.ras_n = 1'b0;
                        next_st.cas_n = 1'b0;
                     end
                     default: begin
                        // Mode set, and any illegal code treated alike
                        next_st.ras_n = 1'b0;
                        next_st.cas_n = 1'b0;
                        next_st.swe_n = 1'b0;
                     end
                  endcase
               end
            end
         end
         EMP_ASYNC: begin
            // Count strobe time; low ready freezes it
            if (!ready_sync) begin
               next_st.hold = st.hold;
            end else if (st.hold != 2'h0) begin
               next_st.hold = st.hold - 2'h1;
            end else begin
               next_st.phase = EMP_IDLE;
               next_st.done = 1'b1;
               next_st.oe_n = 1'b1;
               next_st.rd_n = 1'b1;
               next_st.we_n = 1'b1;
               next_st.drive_data = 1'b0;
            end
         end
         EMP_SDCMD: begin
            // SDRAM commands last one clock
            next_st.phase = EMP_IDLE;
            next_st.done = 1'b1;
            next_st.ras_n = 1'b1;
            next_st.cas_n = 1'b1;
            next_st.swe_n = 1'b1;
            next_st.a10 = 1'b0;
            next_st.drive_data = 1'b0;
         end
         default: begin
            next_st.phase = EMP_IDLE;
         end
      endcase
   end

   // State register; strobes reset high, A10 and clock-enable pins low, data undriven
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{phase: EMP_IDLE, cur: '0, hold: 2'h0, done: 1'b0,
                 oe_n: 1'b1, rd_n: 1'b1, we_n: 1'b1, ras_n: 1'b1,
                 cas_n: 1'b1, swe_n: 1'b1, a10: 1'b0, wdata: 16'h0000,
                 drive_data: 1'b0, flag: 1'b0, gpio: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Output pins; release floats all but clock-enable carriers
   assign async_output_enable_n = st.oe_n;
   assign async_read_strobe_n = st.rd_n;
   assign async_write_strobe_n = st.we_n;
   assign async_output_enable_oe_n = bus_release;
   assign async_read_strobe_oe_n = bus_release;
   assign async_write_strobe_oe_n = bus_release;
   assign sdram_row_strobe_n = st.ras_n;
   assign sdram_column_strobe_n = st.cas_n;
   assign sdram_write_line_n = st.swe_n;
   assign sdram_addr_line_ten = st.a10;
   assign sdram_pins_oe_n = bus_release;
   assign memory_clock_out = clk_div_out;
   assign memory_clock_oe_n = bus_release;
   assign external_flag_pin = st.flag;
   assign general_io_pin_four = st.gpio;
   assign data_out = st.wdata;
   // Data driven only during a write and only when not released
   assign data_oe_n = !st.drive_data || bus_release;
   assign access_done = st.done;

   // Sequences used below
   sequence async_rd_taken_s;
      req_valid && req_ready && is_read;
   endsequence

   // Read request gives both read strobes next cycle
   read_strobes_a: assert property (@(posedge clk) disable iff (!arst_n)
      async_rd_taken_s |=> !async_output_enable_n && !async_read_strobe_n
      && async_write_strobe_n)
      else $error("read strobes missing");

   // Write request gives write strobe and data drive
   write_strobe_a: assert property (@(posedge clk) disable iff (!arst_n)
      req_valid && req_ready && is_write |=> !async_write_strobe_n
      && async_read_strobe_n && st.drive_data)
      else $error("write strobe missing");

   // Low ready keeps the read strobe down
   ready_stretch_a: assert property (@(posedge clk) disable iff (!arst_n)
      st.phase == EMP_ASYNC && !ready_sync |=> st.phase == EMP_ASYNC)
      else $error("access ended while not ready");

   // Release floats strobes
   release_float_a: assert property (@(posedge clk) disable iff (!arst_n)
      bus_release |-> async_read_strobe_oe_n && sdram_pins_oe_n
      && data_oe_n && !req_ready)
      else $error("pins driven while released");

   // Precharge-all encoding
   precharge_code_a: assert property (@(posedge clk) disable iff (!arst_n)
      req_valid && req_ready && req.cmd == emp_pkg::EMP_CMD_SD_PRECHARGE_ALL
      |=> !sdram_row_strobe_n && sdram_column_strobe_n
      && !sdram_write_line_n && sdram_addr_line_ten)
      else $error("bad precharge-all encoding");

   // Refresh encoding
   refresh_code_a: assert property (@(posedge clk) disable iff (!arst_n)
      req_valid && req_ready && req.cmd == emp_pkg::EMP_CMD_SD_REFRESH
      |=> !sdram_row_strobe_n && !sdram_column_strobe_n
      && sdram_write_line_n)
      else $error("bad refresh encoding");

   // Read command carries auto-precharge on A10
   read_a10_a: assert property (@(posedge clk) disable iff (!arst_n)
      req_valid && req_ready && req.cmd == emp_pkg::EMP_CMD_SD_READ
      |=> sdram_addr_line_ten == $past(req.auto_precharge)
      && !sdram_column_strobe_n && sdram_row_strobe_n)
      else $error("bad read command");

   // Idle strobes high
   idle_high_a: assert property (@(posedge clk) disable iff (!arst_n)
      st.phase == EMP_IDLE |-> sdram_row_strobe_n && sdram_column_strobe_n
      && async_read_strobe_n && data_oe_n)
      else $error("strobe active while idle");
endmodule // emp_pins

// ---- dv/emp_mem_model.sv ----
// Asynchronous memory on the far side: answers on the ready pin.
// Assumes the bench sets the stall length before an access starts.
`timescale 1ns/1ps
module emp_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Strobes from the interface
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   // Stall length, zero answers promptly
   input wire logic [3:0] stall_cycles,
   // Ready pin back to the interface
   output logic async_ready_in
);
   logic [3:0] left; // Stall cycles still to hold
   logic served; // Stall already given this access

   // One stall per access, started on the first strobe edge seen
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         left <= 4'h0;
         served <= 1'b0;
      end else if (!(read_strobe_n && write_strobe_n) && !served) begin
         left <= stall_cycles;
         served <= 1'b1;
      end else begin
         if (left != 4'h0) begin
            left <= left - 4'h1;
         end
         // Rearm only once both strobes are back high
         if (read_strobe_n && write_strobe_n) begin
            served <= 1'b0;
         end
      end
   end

   // Ready low while stalling, driven high otherwise
   assign async_ready_in = (left == 4'h0);
endmodule // emp_mem_model

// ---- dv/emp_pins_tb.sv ----
// Self-checking bench for the strobe and pin block with a memory model.
// Assumes the block alone on one 125 MHz clock, no register bus.
`timescale 1ns/1ps
module emp_pins_tb;
   // Clock, reset and host side
   logic clk = 1'b0;
   logic arst_n = 1'b1; // Pulled low at time zero so flops see an edge
   logic req_valid = 1'b0;
   emp_pkg::emp_req_t req = '0;
   logic [1:0] async_hold_cycles = 2'h0;
   logic [15:0] write_data = 16'h0000;
   logic req_ready, access_done;
   // Control bits
   logic bus_release = 1'b0;
   logic memory_clock_on = 1'b0;
   logic [1:0] memory_clock_divider = 2'h0;
   logic sdram_cke = 1'b0;
   emp_pkg::emp_cke_sel_t cke_select = emp_pkg::EMP_CKE_ON_FLAG;
   logic [3:0] stall = 4'h0; // Model stall length
   // Pins
   logic async_ready_in, aoe_n, aoe_oe_n, ard_n, ard_oe_n, awe_n, awe_oe_n;
   logic ras_n, cas_n, swe_n, a10, sd_oe_n, mclk, mclk_oe_n;
   logic flag_pin, gpio_pin, data_oe_n;
   logic [15:0] data_out;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0; // Timeout counter

   // Clock of 8 ns period
   always #4 clk = ~clk;

   emp_pins emp_pins_inst (.clk(clk), .arst_n(arst_n),
      .req_valid(req_valid), .req(req),
      .async_hold_cycles(async_hold_cycles), .write_data(write_data),
      .req_ready(req_ready), .access_done(access_done),
      .bus_release(bus_release), .memory_clock_on(memory_clock_on),
      .memory_clock_divider(memory_clock_divider), .sdram_cke(sdram_cke),
      .cke_select(cke_select), .async_ready_in(async_ready_in),
      .async_output_enable_n(aoe_n), .async_output_enable_oe_n(aoe_oe_n),
      .async_read_strobe_n(ard_n), .async_read_strobe_oe_n(ard_oe_n),
      .async_write_strobe_n(awe_n), .async_write_strobe_oe_n(awe_oe_n),
      .sdram_row_strobe_n(ras_n), .sdram_column_strobe_n(cas_n),
      .sdram_write_line_n(swe_n), .sdram_addr_line_ten(a10),
      .sdram_pins_oe_n(sd_oe_n), .memory_clock_out(mclk),
      .memory_clock_oe_n(mclk_oe_n), .external_flag_pin(flag_pin),
      .general_io_pin_four(gpio_pin), .data_out(data_out),
      .data_oe_n(data_oe_n));

   emp_mem_model emp_mem_model_inst (.clk(clk), .arst_n(arst_n),
      .read_strobe_n(ard_n), .write_strobe_n(awe_n),
      .stall_cycles(stall), .async_ready_in(async_ready_in));

   // Counts the comparison, reports a mismatch at once
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic end_sim();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Presents one request; returns just after the edge that takes it
   task automatic take(input emp_pkg::emp_cmd_t c, input logic a,
                       input logic [1:0] hold, input logic [15:0] wd);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{cmd: c, row_bit_ten: a, auto_precharge: a};
      async_hold_cycles <= hold;
      write_data <= wd;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      check(req_ready, 1'b0); // Busy refuses more
   endtask

   // Bounded wait for completion, then idle pin levels
   task automatic finish(output int n);
      n = 1;
      while (access_done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      check({aoe_n, ard_n, awe_n, ras_n, cas_n, swe_n}, 6'h3f);
      check(data_oe_n, 1'b1);
   endtask

   // Edges between two toggles of the memory clock
   task automatic half_period(output int h);
      logic v;
      h = 0;
      v = mclk;
      while (mclk === v && h < 20) begin
         @(posedge clk);
         #1;
         h++;
      end
      v = mclk;
      h = 0;
      while (mclk === v && h < 20) begin
         @(posedge clk);
         #1;
         h++;
      end
   endtask

   // Hang guard, far above the length of the sequence
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   // Main sequence
   initial begin
      emp_pkg::emp_cmd_t cmds [6];
      int n;
      logic a;
      // A real falling edge, so every asynchronous reset fires
      arst_n <= 1'b0;
      cmds = '{emp_pkg::EMP_CMD_SD_ACTIVATE, emp_pkg::EMP_CMD_SD_READ,
               emp_pkg::EMP_CMD_SD_WRITE, emp_pkg::EMP_CMD_SD_PRECHARGE_ALL,
               emp_pkg::EMP_CMD_SD_REFRESH, emp_pkg::EMP_CMD_SD_MODE_SET};
      repeat (5) @(posedge clk);
      check({ras_n, cas_n, swe_n, mclk, data_oe_n}, 5'h1f);
      arst_n <= 1'b1;
      // Memory clock held high while off
      repeat (6) begin
         @(posedge clk);
         #1;
         check(mclk, 1'b1);
      end
      // Every SDRAM command with both A10 values
      for (int i = 0; i < 12; i++) begin
         a = (i >= 6);
         take(cmds[i % 6], a, 2'h0, 16'h0000);
         case (i % 6)
            0: check({ras_n, cas_n, swe_n, a10}, {3'h3, a});
            1: check({ras_n, cas_n, swe_n, a10}, {3'h5, a});
            2: check({ras_n, cas_n, swe_n, a10}, {3'h4, a});
            3: check({ras_n, cas_n, swe_n, a10}, 4'h5);
            4: check({ras_n, cas_n, swe_n}, 3'h1);
            default: check({ras_n, cas_n, swe_n}, 3'h0);
         endcase
         finish(n);
         check(n, 2);
      end
      // Empty request is taken with no effect on the pins
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '0;
      @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
      #1;
      check({access_done, req_ready, ras_n, cas_n, ard_n}, 5'h0f);
      // Asynchronous read, prompt memory
      take(emp_pkg::EMP_CMD_ASYNC_READ, 1'b0, 2'h0, 16'h0000);
      check({aoe_n, ard_n, awe_n}, 3'h1);
      finish(n);
      check(n, 2);
      // Asynchronous write with one hold cycle
      take(emp_pkg::EMP_CMD_ASYNC_WRITE, 1'b0, 2'h1, 16'ha5c3);
      check({aoe_n, ard_n, awe_n, data_oe_n}, 4'hc);
      check(data_out, 16'ha5c3);
      finish(n);
      check(n, 3);
      // Slow memory stretches a long read
      stall <= 4'h4;
      take(emp_pkg::EMP_CMD_ASYNC_READ, 1'b0, 2'h3, 16'h0000);
      finish(n);
      // Four edges of strobe time plus four of synchronised stall, counted from one
      check(n, 9);
      stall <= 4'h0;
      // Clock enable routed to either pin; flag pin checked during release, general pin after it
      sdram_cke <= 1'b1;
      repeat (3) @(posedge clk);
      bus_release <= 1'b1;
      #1;
      check({aoe_oe_n, ard_oe_n, awe_oe_n}, 3'h7);
      check({sd_oe_n, mclk_oe_n, data_oe_n}, 3'h7);
      check(req_ready, 1'b0);
      check({flag_pin, gpio_pin}, 2'h2);
      @(posedge clk);
      cke_select <= emp_pkg::EMP_CKE_ON_GPIO;
      repeat (3) @(posedge clk);
      bus_release <= 1'b0;
      #1;
      check({flag_pin, gpio_pin}, 2'h1);
      check({aoe_oe_n, ard_oe_n, awe_oe_n, sd_oe_n, mclk_oe_n},
         5'h00);
      // Memory clock rate for every divider code
      memory_clock_on <= 1'b1;
      for (int d = 0; d < 4; d++) begin
         @(posedge clk);
         memory_clock_divider <= d[1:0];
         repeat (12) @(posedge clk);
         #1;
         half_period(n);
         check(n, d + 1);
      end
      end_sim();
   end
endmodule // emp_pins_tb
